/* rtl/nsp_pkg.sv */
/*
 nibble serial port package: register offsets, reset values, field positions,
 states and bus carriers.
 assumes a 4-bit register port and a nibble-wide buffer memory port.
*/
package nsp_pkg;

    localparam logic [8:0] OFF_COUNT_LOW   = 9'h009;
    localparam logic [8:0] OFF_COUNT_HIGH  = 9'h00a;
    localparam logic [8:0] OFF_CLK_DIV     = 9'h00b;
    localparam logic [8:0] OFF_CLK_POL     = 9'h00c;
    localparam logic [8:0] OFF_PORT6_SEL   = 9'h012;
    localparam logic [8:0] OFF_COMMAND     = 9'h0e0;
    localparam logic [8:0] OFF_IRQ_STATUS  = 9'h0e1;
    localparam logic [8:0] OFF_IRQ_MASK    = 9'h0e2;
    localparam logic [8:0] OFF_BUSY        = 9'h0e3;

    localparam logic [3:0] RST_COUNT_LOW   = 4'h2;
    localparam logic [3:0] RST_COUNT_HIGH  = 4'h0;
    localparam logic [3:0] RST_CLK_DIV     = 4'h0;
    localparam logic [3:0] RST_CLK_POL     = 4'h0;
    localparam logic [3:0] RST_PORT6_SEL   = 4'h0;

    // polarity register: bit0 inverts the clock, bit2 enables the read clock, bit3 the write clock
    localparam int POL_INVERT_BIT = 0;
    localparam int POL_RCLK_BIT   = 2;
    localparam int POL_WCLK_BIT   = 3;
    // command register: bit0 starts a send, bit1 starts a receive
    localparam int CMD_SEND_BIT   = 0;
    localparam int CMD_RECV_BIT   = 1;
    // port 6 select: bit0 picks the serial function
    localparam int P6_SERIAL_BIT  = 0;

    localparam logic [8:0] BUF_FIRST = 9'h050;
    localparam logic [8:0] BUF_LAST  = 9'h14e;
    localparam logic [3:0] DIV_CODE_MAX = 4'ha;
    localparam int BITS_PER_NIBBLE = 4;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_STORE = 4'b1000
    } xfer_state_t;

    typedef struct packed {
        logic [8:0] addr;
        logic [3:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic [8:0] addr;
        logic [3:0] wdata;
        logic       wr;
        logic       rd;
    } buf_req_t;

endpackage : nsp_pkg

/* rtl/nsp_clk_div.sv */
/*
 shift clock divider: one tick per half period of fsys / 2^(code+1).
 assumes code 1..10; code 0 is reserved and gives no tick.
*/
`timescale 1ns/1ps
`default_nettype none
module nsp_clk_div
    import nsp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       run,
    input  wire logic [3:0] code,
    output logic            half_tick
);
    logic [10:0] cnt_r;
    logic [10:0] half_len;

    // half period of divide by 2^(code+1) is 2^code cycles
    always_comb begin
        half_len = 11'h000;
        if (code != 4'h0 && code <= DIV_CODE_MAX) begin
            half_len = 11'(11'h001 << code[3:0]) - 11'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst || !run || code == 4'h0 || code > DIV_CODE_MAX) begin
            cnt_r     <= 11'h000;
            half_tick <= 1'b0;
        end else if (cnt_r >= half_len) begin
            cnt_r     <= 11'h000;
            half_tick <= 1'b1;
        end else begin
            cnt_r     <= cnt_r + 11'h001;
            half_tick <= 1'b0;
        end
    end
endmodule : nsp_clk_div
`default_nettype wire

/* rtl/nibble_serial_port.sv */
/*
 nibble serial port: moves a programmed number of nibbles between the serial
 buffer area and an external serial device, LSB first.
 assumes a single-cycle nibble memory port with read data one cycle later,
 and a register port with read data one cycle after the read strobe.
*/
// Design decision made here: the plain strobed port.
// What this block does
// - synchronous shift-clocked send and receive, default length eight bits
// - port 6 pins serve the serial port only when selected
// - transfers are whole nibbles, least significant bit first
// - nibbles come from or go to buffer 050H upward in order
// - nibble count from high and low registers; resets 0 and 2
// - polarity bits 3 and 2 both clear abort and reset the transceiver
// - shift clock is fsys divided by 2^(code+1), code 0 reserved
// - non-inverted clock idles high, data latched on rising edge
// - inverted clock idles low, data latched on falling edge
// - shift clock leaves on whichever clock pin is enabled
// - disabled serial function floats pins and leaves buffer untouched
// - transfer completion raises the serial interrupt request
`timescale 1ns/1ps
`default_nettype none
module nibble_serial_port
    import nsp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire reg_req_t   reg_req,
    output logic [3:0]      reg_rdata,
    output buf_req_t        buf_req,
    input  wire logic [3:0] buf_rdata,
    input  wire logic       sdi_pin,
    output logic            sdo_out,
    output logic            sdo_oe,
    output logic            wclk_out,
    output logic            wclk_oe,
    output logic            rclk_out,
    output logic            rclk_oe,
    output logic            irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic [3:0]  count_low_r;
    logic [3:0]  count_high_r;
    logic [3:0]  clk_div_r;
    logic [3:0]  clk_pol_r;
    logic [3:0]  port6_sel_r;
    logic [3:0]  irq_status_r;
    logic [3:0]  irq_mask_r;
    logic        sdi_meta_r;
    logic        sdi_sync_r;
    xfer_state_t state_r;
    logic        recv_r;
    logic [7:0]  nib_left_r;
    logic [8:0]  buf_addr_r;
    logic [3:0]  shift_r;
    logic [1:0]  bit_idx_r;
    logic        phase_r;
    logic        done_evt;
    logic        half_tick;
    logic        serial_on;
    logic        abort;
    logic        clk_idle;
    logic        start_send;
    logic        start_recv;
    logic        start_ok;
    logic [7:0]  count_total;
    logic        div_ok;

    // receive sampling and fetch pacing
    logic        fetch_wait_r;
    logic [1:0]  rx_dly_r;
    logic        rx_cap_r;
    logic        rx_bit;

    assign serial_on  = port6_sel_r[P6_SERIAL_BIT];
    assign abort      = !clk_pol_r[POL_WCLK_BIT] && !clk_pol_r[POL_RCLK_BIT];
    assign clk_idle   = !clk_pol_r[POL_INVERT_BIT];
    assign start_send = reg_req.wr && reg_req.addr == OFF_COMMAND && reg_req.wdata[CMD_SEND_BIT];
    assign start_recv = reg_req.wr && reg_req.addr == OFF_COMMAND && reg_req.wdata[CMD_RECV_BIT];
    assign count_total = {count_high_r, count_low_r};
    // a reserved or out-of-range speed code would leave the shift clock stalled
    assign div_ok      = clk_div_r != 4'h0 && clk_div_r <= DIV_CODE_MAX;
    // start needs a nonzero count and a usable speed code
    assign start_ok    = (start_send || start_recv) && count_total != 8'h00 && div_ok;

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            count_low_r  <= RST_COUNT_LOW;
            count_high_r <= RST_COUNT_HIGH;
            clk_div_r    <= RST_CLK_DIV;
            clk_pol_r    <= RST_CLK_POL;
            port6_sel_r  <= RST_PORT6_SEL;
            irq_mask_r   <= 4'h0;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                OFF_COUNT_LOW:  count_low_r  <= reg_req.wdata;
                OFF_COUNT_HIGH: count_high_r <= reg_req.wdata;
                OFF_CLK_DIV:    clk_div_r    <= reg_req.wdata;
                OFF_CLK_POL:    clk_pol_r    <= reg_req.wdata;
                OFF_PORT6_SEL:  port6_sel_r  <= reg_req.wdata;
                OFF_IRQ_MASK:   irq_mask_r   <= reg_req.wdata;
                default:        ;
            endcase
        end
    end

    // sticky done flag, set wins over write-one-to-clear
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq_status_r <= 4'h0;
        end else begin
            if (reg_req.wr && reg_req.addr == OFF_IRQ_STATUS) begin
                irq_status_r <= irq_status_r & ~reg_req.wdata;
            end
            if (done_evt) begin
                irq_status_r[0] <= 1'b1;
            end
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_r & irq_mask_r);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            reg_rdata <= 4'h0;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                OFF_COUNT_LOW:  reg_rdata <= count_low_r;
                OFF_COUNT_HIGH: reg_rdata <= count_high_r;
                OFF_CLK_DIV:    reg_rdata <= clk_div_r;
                OFF_CLK_POL:    reg_rdata <= clk_pol_r;
                OFF_PORT6_SEL:  reg_rdata <= port6_sel_r;
                OFF_IRQ_STATUS: reg_rdata <= irq_status_r;
                OFF_IRQ_MASK:   reg_rdata <= irq_mask_r;
                OFF_BUSY:       reg_rdata <= {2'b00, recv_r, state_r != ST_IDLE};
                default:        reg_rdata <= 4'h0;
            endcase
        end else begin
            reg_rdata <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input pin synchroniser
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sdi_meta_r <= 1'b0;
            sdi_sync_r <= 1'b0;
        end else begin
            sdi_meta_r <= sdi_pin;
            sdi_sync_r <= sdi_meta_r;
        end
    end

    // receive sample: the synchronised pin one cycle after the clock returns to idle,
    // which is the pin level one cycle before that edge; the far side may change data soon after
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rx_dly_r <= 2'b00;
            rx_cap_r <= 1'b0;
        end else begin
            rx_dly_r <= {rx_dly_r[0], state_r == ST_SHIFT && half_tick && !phase_r};
            if (rx_dly_r[1]) begin
                rx_cap_r <= sdi_sync_r;
            end
        end
    end

    // at the fastest speed code the capture and the shift share an edge
    assign rx_bit = rx_dly_r[1] ? sdi_sync_r : rx_cap_r;

    nsp_clk_div u_div (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .run       (state_r == ST_SHIFT),
        .code      (clk_div_r),
        .half_tick (half_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // transfer sequencer: fetch nibble, shift four bits, store nibble
    always_ff @(posedge ref_clk) begin
        if (!nrst || abort || !serial_on) begin
            state_r    <= ST_IDLE;
            recv_r     <= 1'b0;
            nib_left_r <= 8'h00;
            buf_addr_r <= BUF_FIRST;
            shift_r    <= 4'h0;
            bit_idx_r  <= 2'd0;
            phase_r    <= 1'b0;
            done_evt   <= 1'b0;
            fetch_wait_r <= 1'b0;
        end else begin
            done_evt <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (start_ok) begin
                        nib_left_r <= count_total;
                        buf_addr_r <= BUF_FIRST;
                        recv_r     <= start_recv && !start_send;
                        fetch_wait_r <= 1'b1;
                        state_r    <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    // read data stands one cycle after the buffer read strobe
                    fetch_wait_r <= 1'b0;
                    if (!fetch_wait_r) begin
                        shift_r   <= buf_rdata;
                        bit_idx_r <= 2'd0;
                        phase_r   <= 1'b0;
                        state_r   <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (half_tick) begin
                        phase_r <= !phase_r;
                        if (phase_r) begin
                            // end of the idle half period, at the next leading edge: one bit per period
                            if (recv_r) begin
                                shift_r <= {rx_bit, shift_r[3:1]};
                            end else begin
                                shift_r <= {1'b0, shift_r[3:1]};
                            end
                            bit_idx_r <= bit_idx_r + 2'd1;
                            if (bit_idx_r == 2'(BITS_PER_NIBBLE - 1)) begin
                                state_r <= ST_STORE;
                            end
                        end
                    end
                end
                ST_STORE: begin
                    nib_left_r <= nib_left_r - 8'h01;
                    buf_addr_r <= (buf_addr_r == BUF_LAST) ? BUF_FIRST : buf_addr_r + 9'h001;
                    if (nib_left_r == 8'h01) begin
                        state_r  <= ST_IDLE;
                        done_evt <= 1'b1;
                    end else begin
                        state_r      <= ST_FETCH;
                        fetch_wait_r <= 1'b1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // buffer port: read on fetch entry, write on store when receiving
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            buf_req <= '0;
        end else begin
            // a new transfer always begins at the first buffer location
            buf_req.addr  <= (state_r == ST_IDLE) ? BUF_FIRST : buf_addr_r;
            buf_req.wdata <= shift_r;
            buf_req.rd    <= serial_on && !abort && state_r == ST_IDLE && start_ok;
            buf_req.wr    <= serial_on && !abort && state_r == ST_SHIFT && recv_r && half_tick && phase_r
                             && bit_idx_r == 2'(BITS_PER_NIBBLE - 1);
            if (state_r == ST_STORE && nib_left_r != 8'h01) begin
                buf_req.rd   <= 1'b1;
                buf_req.addr <= (buf_addr_r == BUF_LAST) ? BUF_FIRST : buf_addr_r + 9'h001;
            end
            if (state_r == ST_SHIFT && recv_r && half_tick && phase_r) begin
                buf_req.wdata <= {rx_bit, shift_r[3:1]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins: clock leaves its idle level on the first half period
    // data changes with the leading clock edge, so it is steady at the latching edge
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wclk_out <= 1'b1;
            rclk_out <= 1'b1;
            wclk_oe  <= 1'b0;
            rclk_oe  <= 1'b0;
            sdo_out  <= 1'b0;
            sdo_oe   <= 1'b0;
        end else begin
            wclk_out <= (state_r == ST_SHIFT && !phase_r) ? !clk_idle : clk_idle;
            rclk_out <= (state_r == ST_SHIFT && !phase_r) ? !clk_idle : clk_idle;
            wclk_oe  <= serial_on && clk_pol_r[POL_WCLK_BIT];
            rclk_oe  <= serial_on && clk_pol_r[POL_RCLK_BIT];
            sdo_out  <= shift_r[0];
            sdo_oe   <= serial_on && !abort && !recv_r;
        end
    end
endmodule : nibble_serial_port
`default_nettype wire

/* sim/nsp_sva.sv */
/*
 checker for the nibble serial port ports: bus answer, buffer port, pin idle
 and hold, abort, float and interrupt masking.
 assumes one clock ref_clk and synchronous active-low nrst; bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module nsp_sva
    import nsp_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       nrst,
    input wire reg_req_t   reg_req,
    input wire logic [3:0] reg_rdata,
    input wire buf_req_t   buf_req,
    input wire logic       sdo_oe,
    input wire logic       wclk_out,
    input wire logic       wclk_oe,
    input wire logic       rclk_out,
    input wire logic       rclk_oe,
    input wire logic       irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire logic pol_off = reg_req.wr && reg_req.addr == OFF_CLK_POL && reg_req.wdata[3:2] == 2'b00;
    wire logic sel_off = reg_req.wr && reg_req.addr == OFF_PORT6_SEL && !reg_req.wdata[P6_SERIAL_BIT];
    wire logic no_oe   = !sdo_oe && !wclk_oe && !rclk_oe;
    ////////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!reg_req.rd |=> reg_rdata == 4'h0)
        else $error("read data standing outside a read answer");
    buf_range_a: assert property ((buf_req.rd || buf_req.wr) |-> buf_req.addr >= BUF_FIRST && buf_req.addr <= BUF_LAST)
        else $error("buffer access outside the serial area");
    one_strobe_a: assert property (!(buf_req.rd && buf_req.wr))
        else $error("buffer read and write together");
    reset_idle_a: assert property ($rose(nrst) |-> wclk_out && rclk_out && no_oe && !irq)
        else $error("pins not idle after reset");
    wclk_hold_a: assert property (wclk_oe && $changed(wclk_out) |=> !wclk_oe || $stable(wclk_out))
        else $error("write clock half period below two cycles");
    rclk_hold_a: assert property (rclk_oe && $changed(rclk_out) |=> !rclk_oe || $stable(rclk_out))
        else $error("read clock half period below two cycles");
    abort_idle_a: assert property (pol_off |-> ##2 no_oe)
        else $error("pins still driven after clock enables cleared");
    float_off_a: assert property (sel_off |-> ##2 no_oe)
        else $error("pins driven with serial function off");
    irq_mask_a: assert property (reg_req.wr && reg_req.addr == OFF_IRQ_MASK && reg_req.wdata == 4'h0 |=> ##1 !irq)
        else $error("interrupt high with mask cleared");
    c_irq: cover property ($rose(irq));
    c_store: cover property (buf_req.wr);
    c_rclk: cover property (rclk_oe && $fell(rclk_out));
endmodule : nsp_sva
bind nibble_serial_port nsp_sva i_sva (.ref_clk(ref_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .buf_req(buf_req), .sdo_oe(sdo_oe), .wclk_out(wclk_out), .wclk_oe(wclk_oe), .rclk_out(rclk_out),
    .rclk_oe(rclk_oe), .irq(irq));
`default_nettype wire

/* sim/nsp_serial_dev.sv */
/*
 external serial device model: latches sdo at the return of the shift clock to
 its idle level, puts the next pattern bit on sdi at the leading edge.
 assumes the bench resolves the clock pin and tells the polarity.
*/
`timescale 1ns/1ps
`default_nettype none
module nsp_serial_dev (
    input  wire logic        ref_clk,
    input  wire logic        clear,
    input  wire logic        inv,
    input  wire logic        sck_en,
    input  wire logic        sck,
    input  wire logic        sdo_oe,
    input  wire logic        sdo,
    input  wire logic [63:0] tx_pat,
    output logic             sdi = 1'b0,
    output logic [63:0]      got,
    output logic [7:0]       got_n,
    output logic [15:0]      first_gap
);
    logic        sck_q;
    logic [7:0]  tx_n;
    logic [15:0] gap;
    wire logic   idle_lvl = ~inv;
    always @(posedge ref_clk) begin
        sck_q <= sck_en ? sck : idle_lvl;
        gap <= gap + 16'h1;
        if (clear) begin
            got <= 64'h0;
            got_n <= 8'h0;
            tx_n <= 8'h0;
            first_gap <= 16'h0;
        end else if (sck_en && sck != idle_lvl && sck_q == idle_lvl) begin
            sdi <= tx_pat[tx_n[5:0]];
            tx_n <= tx_n + 8'h1;
        end else if (sck_en && sck == idle_lvl && sck_q != idle_lvl) begin
            // rising edge when idle high, falling when idle low
            if (sdo_oe) got[got_n[5:0]] <= sdo;
            got_n <= got_n + 8'h1;
            // hold time over: line shows the inverse
            sdi <= ~sdi;
            gap <= 16'h1;
            if (got_n == 8'h1) first_gap <= gap;
        end
    end
endmodule : nsp_serial_dev
`default_nettype wire

/* sim/testbench.sv */
/*
 testbench for nibble_serial_port: register rows, send, receive, abort and
 disabled port. assumes the device model and a nibble buffer memory here.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
    import nsp_pkg::*;
;
    typedef struct packed {
        logic [8:0] addr;
        logic [3:0] wdata;
        logic [3:0] rst_v;
        logic [3:0] rw_v;
    } row_t;
    localparam logic [63:0] PAT = 64'h3c5a_e1f0_9687_d2b4;
    row_t       rows [0:5] = '{'{OFF_COUNT_LOW, 4'h5, RST_COUNT_LOW, 4'h5}, '{OFF_COUNT_HIGH, 4'h1, RST_COUNT_HIGH, 4'h1},
                               '{OFF_CLK_DIV, 4'h3, RST_CLK_DIV, 4'h3}, '{OFF_CLK_POL, 4'h8, RST_CLK_POL, 4'h8},
                               '{OFF_PORT6_SEL, 4'h1, RST_PORT6_SEL, 4'h1}, '{9'h1ff, 4'h7, 4'h0, 4'h0}};
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        dev_clr = 1'b1;
    logic        inv = 1'b0;
    reg_req_t    req = '0;
    buf_req_t    breq;
    logic [3:0]  rdata, d;
    logic [3:0]  buf_rdata = 4'h0;
    logic [3:0]  mem [0:511];
    logic        sdi, sdo_out, sdo_oe, wclk_out, wclk_oe, rclk_out, rclk_oe, irq;
    logic [63:0] got;
    logic [7:0]  got_n;
    logic [15:0] gap1;
    int          error_cnt = 0;
    int          total_checks = 0;
    nibble_serial_port i_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_req(req), .reg_rdata(rdata), .buf_req(breq),
        .buf_rdata(buf_rdata), .sdi_pin(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .wclk_out(wclk_out),
        .wclk_oe(wclk_oe), .rclk_out(rclk_out), .rclk_oe(rclk_oe), .irq(irq));
    nsp_serial_dev i_dev (.ref_clk(ref_clk), .clear(dev_clr), .inv(inv), .sck_en(wclk_oe | rclk_oe),
        .sck(wclk_oe ? wclk_out : rclk_out), .sdo_oe(sdo_oe), .sdo(sdo_out), .tx_pat(PAT), .sdi(sdi),
        .got(got), .got_n(got_n), .first_gap(gap1));
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (breq.wr) mem[breq.addr] <= breq.wdata;
        buf_rdata <= breq.rd ? mem[breq.addr] : ~buf_rdata;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle
    task automatic wr(input logic [8:0] a, input logic [3:0] v);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [8:0] a, output logic [3:0] v);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd
    task automatic wait_done();
        logic [3:0] s = 4'h0;
        for (int i = 0; i < 600 && s[0] !== 1'b1; i++) rd(OFF_IRQ_STATUS, s);
        chk("done status", s, 4'h1);
    endtask : wait_done
    task automatic stop_test();
        if (error_cnt == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    initial begin
        #400000;
        error_cnt++;
        stop_test();
    end
    initial begin
        mem[9'h050] = 4'h6;
        mem[9'h051] = 4'h9;
        idle(3);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].addr, d);
            chk("reset value", d, rows[i].rst_v);
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, d);
            chk("read back", d, rows[i].rw_v);
        end
        nrst <= 1'b0;
        idle(3);
        nrst <= 1'b1;
        dev_clr <= 1'b0;
        wr(OFF_PORT6_SEL, 4'h1);
        wr(OFF_CLK_DIV, 4'h1);
        wr(OFF_CLK_POL, 4'h8);
        wr(OFF_IRQ_MASK, 4'h1);
        chk("write clock idle", wclk_out, 1'b1);
        wr(OFF_COMMAND, 4'h1);
        wait_done();
        chk("bits sent", got_n, 8'd8);
        chk("sent data", got[7:0], 8'h96);
        chk("shift period", gap1, 16'd4);
        chk("irq raised", irq, 1'b1);
        wr(OFF_IRQ_STATUS, 4'h1);
        rd(OFF_IRQ_STATUS, d);
        chk("status cleared", {irq, d}, 5'h0);
        dev_clr <= 1'b1;
        inv <= 1'b1;
        wr(OFF_COUNT_HIGH, 4'h1);
        wr(OFF_COUNT_LOW, 4'h0);
        wr(OFF_CLK_DIV, 4'h2);
        wr(OFF_IRQ_MASK, 4'h0);
        wr(OFF_CLK_POL, 4'h5);
        idle(3);
        chk("read clock idle", rclk_out, 1'b0);
        dev_clr <= 1'b0;
        wr(OFF_COMMAND, 4'h2);
        wait_done();
        chk("irq masked", irq, 1'b0);
        chk("bits received", got_n, 8'd64);
        for (int i = 0; i < 16; i++) chk("stored nibble", mem[9'h050 + i], PAT[4*i +: 4]);
        wr(OFF_IRQ_MASK, 4'h1);
        idle(2);
        chk("irq unmasked", irq, 1'b1);
        wr(OFF_IRQ_STATUS, 4'h1);
        inv <= 1'b0;
        wr(OFF_CLK_POL, 4'h8);
        wr(OFF_COMMAND, 4'h1);
        idle(30);
        chk("clock driven", wclk_oe, 1'b1);
        rd(OFF_BUSY, d);
        chk("busy before abort", d, 4'h1);
        wr(OFF_CLK_POL, 4'h0);
        idle(3);
        chk("abort pins", {sdo_oe, wclk_oe, rclk_oe}, 3'b000);
        rd(OFF_BUSY, d);
        chk("abort busy", d, 4'h0);
        rd(OFF_IRQ_STATUS, d);
        chk("abort no irq", d, 4'h0);
        dev_clr <= 1'b1;
        wr(OFF_PORT6_SEL, 4'h0);
        wr(OFF_CLK_POL, 4'h8);
        dev_clr <= 1'b0;
        wr(OFF_COMMAND, 4'h2);
        idle(100);
        chk("disabled pins", {sdo_oe, wclk_oe, rclk_oe, got_n}, 11'h0);
        chk("buffer kept", mem[9'h050], PAT[3:0]);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
